// file: common/ifra_pkg.sv
// ============================================================
// Shared constants and types of the indirect fabric access port.
package ifra_pkg;

  localparam logic [11:0] DATA_REG_OFFSET = 12'h01ac;
  localparam logic [11:0] COMMAND_REG_OFFSET = 12'h01b0;

  localparam int BUSY_BIT = 31;
  localparam int DIR_BIT = 30;
  localparam int STEP_UP_BIT = 29;
  localparam int STEP_DOWN_BIT = 28;
  localparam int LANES_MSB = 19;
  localparam int LANES_LSB = 16;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 0;

  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [3:0] LANES_RESET = 4'h0;
  localparam logic [15:0] ADDR_ONE = 16'h0001;

  typedef struct packed {
    logic write_en;
    logic [3:0] lanes;
    logic [15:0] addr;
    logic [31:0] wdata;
  } ifra_fab_req_s;

endpackage : ifra_pkg

// file: hdl/ifra_fabric_engine.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Carries one access to the fabric: holds the request until the
// fabric acknowledges it, then reports completion for one cycle.
module ifra_fabric_engine
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire ifra_pkg::ifra_fab_req_s req_in,
  input wire logic ack_in,
  input wire logic [31:0] ack_data_in,
  output logic fab_req_out,
  output ifra_pkg::ifra_fab_req_s fab_cmd_out,
  output logic done_out,
  output logic done_read_out,
  output logic [31:0] done_data_out
);

  typedef enum logic [0:0] {ENG_IDLE, ENG_WAIT} ifra_eng_e;

  ifra_eng_e state_r;

  // ============================================================
  // Request sequencing.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= ENG_IDLE;
      fab_req_out <= 1'b0;
      fab_cmd_out <= '0;
      done_out <= 1'b0;
      done_read_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      unique case (state_r)
        ENG_IDLE:
        begin
          if (start_in)
          begin
            fab_cmd_out <= req_in;
            fab_req_out <= 1'b1;
            state_r <= ENG_WAIT;
          end
        end
        ENG_WAIT:
        begin
          if (ack_in)
          begin
            fab_req_out <= 1'b0;
            done_out <= 1'b1;
            done_read_out <= !fab_cmd_out.write_en;
            state_r <= ENG_IDLE;
          end
        end
      endcase
    end
  end

  // ============================================================
  // Read data capture at completion.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      done_data_out <= ifra_pkg::DATA_RESET;
    end
    else if (state_r == ENG_WAIT && ack_in)
    begin
      done_data_out <= ack_data_in;
    end
  end

endmodule : ifra_fabric_engine
`default_nettype wire

// file: hdl/ifra_top.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Indirect access port: a data and a command register through which
// the host reaches the fabric's internal registers.
// Contract
// - The data register holds the value moved to or from the fabric register at the target address.
// - A host read of the data register returns fabric data in read direction, else the last host write.
// - Writing one to command bit 31 launches one fabric access in the selected direction.
// - The busy bit stays set during the access and clears at completion, marking read data valid.
// - Command bit 30 selects a fabric write when zero and a fabric read when one.
// - With step-up set, a data write launches the access and the address rises by one when it ends.
// - With step-up set in read direction, a data read raises the address by one and launches a read there.
// - With step-down set, a data write launches the access and the address falls by one when it ends.
// - With step-down set in read direction, a data read lowers the address by one and launches a read there.
// - When both stepping bits are set, step-up applies and step-down is ignored.
// - After reset the data register and the busy, direction and stepping bits read zero.
// - Command bits 19:16 are per-byte write enables, lane 3 for bits 31:24 and lane 0 for 7:0.
// - Command bits 15:0 hold the target address, read-write, resetting to zero.
module ifra_top
(
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [11:0] HOST_ADDR_IN,
  input wire logic HOST_WR_IN,
  input wire logic HOST_RD_IN,
  input wire logic [31:0] HOST_WDATA_IN,
  output logic [31:0] HOST_RDATA_OUT,
  output logic FAB_REQ_OUT,
  output logic FAB_WRITE_OUT,
  output logic [3:0] FAB_LANES_OUT,
  output logic [15:0] FAB_ADDR_OUT,
  output logic [31:0] FAB_WDATA_OUT,
  input wire logic FAB_ACK_IN,
  input wire logic [31:0] FAB_RDATA_IN
);

  logic busy_r;
  logic dir_read_r;
  logic step_up_r;
  logic step_down_r;
  logic [3:0] lanes_r;
  logic [15:0] addr_r;
  logic [15:0] addr_nxt;
  logic [31:0] host_data_r;
  logic [31:0] fabric_data_r;
  logic sel_data;
  logic sel_cmd;
  logic data_wr;
  logic data_rd;
  logic cmd_wr;
  logic auto_step;
  logic start;
  logic [15:0] start_addr;
  logic [15:0] stepped_addr;
  logic step_after_write_r;
  logic done;
  logic done_read;
  logic [31:0] done_data;
  logic [31:0] cmd_view;
  ifra_pkg::ifra_fab_req_s req;
  ifra_pkg::ifra_fab_req_s fab_cmd;

  // ============================================================
  // Decode and launch.
  assign sel_data = (HOST_ADDR_IN == ifra_pkg::DATA_REG_OFFSET);
  assign sel_cmd = (HOST_ADDR_IN == ifra_pkg::COMMAND_REG_OFFSET);
  assign data_wr = HOST_WR_IN && sel_data && !busy_r;
  assign data_rd = HOST_RD_IN && sel_data && !busy_r;
  assign cmd_wr = HOST_WR_IN && sel_cmd && !busy_r;
  assign auto_step = step_up_r || step_down_r;

  // Step-up wins when both stepping bits are set.
  assign stepped_addr = step_up_r ? (addr_r + ifra_pkg::ADDR_ONE)
                                  : (addr_r - ifra_pkg::ADDR_ONE);

  assign start = (cmd_wr && HOST_WDATA_IN[ifra_pkg::BUSY_BIT])
              || (data_wr && auto_step)
              || (data_rd && auto_step && dir_read_r);

  // A stepped read targets the new address straight away.
  assign start_addr = cmd_wr ? HOST_WDATA_IN[ifra_pkg::ADDR_MSB:ifra_pkg::ADDR_LSB]
                    : (data_rd ? stepped_addr : addr_r);

  assign req.write_en = cmd_wr ? !HOST_WDATA_IN[ifra_pkg::DIR_BIT] : !dir_read_r;
  assign req.lanes = cmd_wr ? HOST_WDATA_IN[ifra_pkg::LANES_MSB:ifra_pkg::LANES_LSB]
                   : lanes_r;
  assign req.addr = start_addr;
  assign req.wdata = data_wr ? HOST_WDATA_IN : host_data_r;

  ifra_fabric_engine u_engine
  (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .start_in(start),
    .req_in(req),
    .ack_in(FAB_ACK_IN),
    .ack_data_in(FAB_RDATA_IN),
    .fab_req_out(FAB_REQ_OUT),
    .fab_cmd_out(fab_cmd),
    .done_out(done),
    .done_read_out(done_read),
    .done_data_out(done_data)
  );

  assign FAB_WRITE_OUT = fab_cmd.write_en;
  assign FAB_LANES_OUT = fab_cmd.lanes;
  assign FAB_ADDR_OUT = fab_cmd.addr;
  assign FAB_WDATA_OUT = fab_cmd.wdata;

  // ============================================================
  // Command register.
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      dir_read_r <= 1'b0;
      step_up_r <= 1'b0;
      step_down_r <= 1'b0;
      lanes_r <= ifra_pkg::LANES_RESET;
    end
    else if (cmd_wr)
    begin
      dir_read_r <= HOST_WDATA_IN[ifra_pkg::DIR_BIT];
      step_up_r <= HOST_WDATA_IN[ifra_pkg::STEP_UP_BIT];
      step_down_r <= HOST_WDATA_IN[ifra_pkg::STEP_DOWN_BIT];
      lanes_r <= HOST_WDATA_IN[ifra_pkg::LANES_MSB:ifra_pkg::LANES_LSB];
    end
  end

  // ============================================================
  // Busy bit: set by a launch, cleared by the fabric's completion.
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      busy_r <= 1'b0;
    end
    else if (start)
    begin
      busy_r <= 1'b1;
    end
    else if (done)
    begin
      busy_r <= 1'b0;
    end
  end

  // ============================================================
  // Target address, with stepping after writes and before reads.
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      step_after_write_r <= 1'b0;
    end
    else if (start)
    begin
      step_after_write_r <= data_wr && auto_step;
    end
    else if (done)
    begin
      step_after_write_r <= 1'b0;
    end
  end

  always_comb
  begin
    addr_nxt = addr_r;
    if (cmd_wr)
    begin
      addr_nxt = HOST_WDATA_IN[ifra_pkg::ADDR_MSB:ifra_pkg::ADDR_LSB];
    end
    else if (data_rd && auto_step && dir_read_r)
    begin
      addr_nxt = stepped_addr;
    end
    else if (done && step_after_write_r)
    begin
      addr_nxt = stepped_addr;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      addr_r <= ifra_pkg::ADDR_RESET;
    end
    else
    begin
      addr_r <= addr_nxt;
    end
  end

  // ============================================================
  // Data holding: host value and fabric value kept apart.
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      host_data_r <= ifra_pkg::DATA_RESET;
    end
    else if (data_wr)
    begin
      host_data_r <= HOST_WDATA_IN;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      fabric_data_r <= ifra_pkg::DATA_RESET;
    end
    else if (done && done_read)
    begin
      fabric_data_r <= done_data;
    end
  end

  // ============================================================
  // Host read path, registered one cycle after the strobe.
  always_comb
  begin
    cmd_view = 32'h0000_0000;
    cmd_view[ifra_pkg::BUSY_BIT] = busy_r;
    cmd_view[ifra_pkg::DIR_BIT] = dir_read_r;
    cmd_view[ifra_pkg::STEP_UP_BIT] = step_up_r;
    cmd_view[ifra_pkg::STEP_DOWN_BIT] = step_down_r;
    cmd_view[ifra_pkg::LANES_MSB:ifra_pkg::LANES_LSB] = lanes_r;
    cmd_view[ifra_pkg::ADDR_MSB:ifra_pkg::ADDR_LSB] = addr_r;
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      HOST_RDATA_OUT <= ifra_pkg::DATA_RESET;
    end
    else if (HOST_RD_IN && sel_data)
    begin
      HOST_RDATA_OUT <= dir_read_r ? fabric_data_r : host_data_r;
    end
    else if (HOST_RD_IN && sel_cmd)
    begin
      HOST_RDATA_OUT <= cmd_view;
    end
    else if (HOST_RD_IN)
    begin
      HOST_RDATA_OUT <= 32'h0000_0000;
    end
  end

endmodule : ifra_top
`default_nettype wire

// file: tb/ifra_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port checks of the indirect fabric access port.
module ifra_chk
(
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [11:0] HOST_ADDR_IN,
  input wire logic HOST_WR_IN,
  input wire logic HOST_RD_IN,
  input wire logic [31:0] HOST_WDATA_IN,
  input wire logic [31:0] HOST_RDATA_OUT,
  input wire logic FAB_REQ_OUT,
  input wire logic FAB_WRITE_OUT,
  input wire logic [3:0] FAB_LANES_OUT,
  input wire logic [15:0] FAB_ADDR_OUT,
  input wire logic [31:0] FAB_WDATA_OUT,
  input wire logic FAB_ACK_IN,
  input wire logic [31:0] FAB_RDATA_IN
);
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  logic cmd_wr;
  logic [31:0] last_wd_r;
  assign cmd_wr = HOST_WR_IN && HOST_ADDR_IN == ifra_pkg::COMMAND_REG_OFFSET;
  // Keeps the last host data word, which a fabric write must carry.
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      last_wd_r <= 32'h0000_0000;
    else if (HOST_WR_IN && HOST_ADDR_IN == ifra_pkg::DATA_REG_OFFSET && !FAB_REQ_OUT)
      last_wd_r <= HOST_WDATA_IN;
  end
  property p_launch;
    cmd_wr && HOST_WDATA_IN[31] && !FAB_REQ_OUT && !$past(FAB_REQ_OUT) |=> FAB_REQ_OUT
      && FAB_WRITE_OUT == !$past(HOST_WDATA_IN[30]) && FAB_ADDR_OUT == $past(HOST_WDATA_IN[15:0])
      && FAB_LANES_OUT == $past(HOST_WDATA_IN[19:16]);
  endproperty
  a_launch: assert property (p_launch) else $error("launch mismatch");
  property p_hold;
    FAB_REQ_OUT && !FAB_ACK_IN |=> FAB_REQ_OUT && $stable(FAB_ADDR_OUT) && $stable(FAB_WRITE_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("request not held");
  property p_drop;
    FAB_REQ_OUT && FAB_ACK_IN |=> !FAB_REQ_OUT [*2];
  endproperty
  a_drop: assert property (p_drop) else $error("request not ended");
  property p_quiet;
    !FAB_REQ_OUT && !HOST_WR_IN && !HOST_RD_IN |=> !FAB_REQ_OUT;
  endproperty
  a_quiet: assert property (p_quiet) else $error("request without host access");
  property p_unmapped;
    HOST_RD_IN && HOST_ADDR_IN != ifra_pkg::DATA_REG_OFFSET
      && HOST_ADDR_IN != ifra_pkg::COMMAND_REG_OFFSET |=> HOST_RDATA_OUT == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_hold;
    !HOST_RD_IN |=> $stable(HOST_RDATA_OUT);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed");
  property p_busy_rd;
    FAB_REQ_OUT && HOST_RD_IN && HOST_ADDR_IN == ifra_pkg::COMMAND_REG_OFFSET |=> HOST_RDATA_OUT[31];
  endproperty
  a_busy_rd: assert property (p_busy_rd) else $error("busy low during access");
  property p_wdata;
    $rose(FAB_REQ_OUT) && FAB_WRITE_OUT |-> FAB_WDATA_OUT == last_wd_r;
  endproperty
  a_wdata: assert property (p_wdata) else $error("fabric write data wrong");
  c_wr: cover property (FAB_REQ_OUT && FAB_WRITE_OUT && FAB_ACK_IN);
  c_rd: cover property (FAB_REQ_OUT && !FAB_WRITE_OUT && FAB_ACK_IN);
  c_busy: cover property (FAB_REQ_OUT && HOST_RD_IN);
endmodule : ifra_chk
bind ifra_top ifra_chk u_chk (.SYS_CLK_IN, .RST_N_IN, .HOST_ADDR_IN, .HOST_WR_IN, .HOST_RD_IN,
  .HOST_WDATA_IN, .HOST_RDATA_OUT, .FAB_REQ_OUT, .FAB_WRITE_OUT, .FAB_LANES_OUT, .FAB_ADDR_OUT,
  .FAB_WDATA_OUT, .FAB_ACK_IN, .FAB_RDATA_IN);
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host-side tests with a behavioural fabric.
module tb_top;
  localparam logic [11:0] dr = ifra_pkg::DATA_REG_OFFSET;
  localparam logic [11:0] cr = ifra_pkg::COMMAND_REG_OFFSET;
  logic clk, rst_n, wr, rd, ack, freq, fwr;
  logic [11:0] addr;
  logic [31:0] wd, rdo, fab_rd, fwd;
  logic [3:0] flanes;
  logic [15:0] faddr;
  logic [31:0] mem [16];
  int fail_count, num_checks, wait_c, ack_dly;
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ifra_top DUT (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .HOST_ADDR_IN(addr), .HOST_WR_IN(wr),
    .HOST_RD_IN(rd), .HOST_WDATA_IN(wd), .HOST_RDATA_OUT(rdo), .FAB_REQ_OUT(freq),
    .FAB_WRITE_OUT(fwr), .FAB_LANES_OUT(flanes), .FAB_ADDR_OUT(faddr), .FAB_WDATA_OUT(fwd),
    .FAB_ACK_IN(ack), .FAB_RDATA_IN(fab_rd));
  // Fabric answers after ack_dly cycles; idle read data toggles.
  always @(negedge clk)
  begin
    if (freq === 1'b1 && wait_c >= ack_dly)
    begin
      ack = 1'b1;
      fab_rd = mem[faddr[3:0]];
      for (int i = 0; i < 4; i++)
        if (fwr && flanes[i]) mem[faddr[3:0]][8*i+:8] = fwd[8*i+:8];
      wait_c = 0;
    end
    else
    begin
      ack = 1'b0;
      fab_rd = ~fab_rd;
      if (freq === 1'b1) wait_c++;
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic hw(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : hw
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string n);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    chk(n, e, rdo);
  endtask : rc
  task automatic bw;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge clk);
      addr = cr;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      if (rdo[31] === 1'b0) return;
    end
    $display("unexpected busy: expected 0 seen 1");
    fail_count++;
    report_and_stop;
  endtask : bw
  task automatic t_basic;
    rc(dr, 32'h0000_0000, "data");
    rc(cr, 32'h0000_0000, "command");
    hw(dr, 32'h1234_5678);
    hw(cr, 32'h8005_0002);
    bw;
    chk("lanes", 32'h0234_0278, mem[2]);
    rc(dr, 32'h1234_5678, "host data");
    rc(cr, 32'h0005_0002, "command");
    hw(12'h01b4, 32'hffff_ffff);
    rc(12'h01b4, 32'h0000_0000, "unmapped");
    ack_dly = 3;
    hw(cr, 32'hc000_0003);
    bw;
    rc(dr, 32'h0303_0303, "fabric data");
    $display("test basic done");
  endtask : t_basic
  task automatic t_step_wr;
    ack_dly = 1;
    hw(cr, 32'h200f_ffff);
    hw(dr, 32'haaaa_0001);
    bw;
    hw(dr, 32'hbbbb_0002);
    bw;
    chk("wrap low", 32'haaaa_0001, mem[15]);
    chk("wrap high", 32'hbbbb_0002, mem[0]);
    rc(cr, 32'h200f_0001, "command");
    hw(cr, 32'h100f_0001);
    hw(dr, 32'hcccc_0003);
    bw;
    chk("down", 32'hcccc_0003, mem[1]);
    rc(cr, 32'h100f_0000, "command");
    hw(cr, 32'h300f_0005);
    hw(dr, 32'hdddd_0004);
    bw;
    chk("both", 32'hdddd_0004, mem[5]);
    rc(dr, 32'hdddd_0004, "write dir data");
    rc(cr, 32'h300f_0006, "command");
    $display("test stepped write done");
  endtask : t_step_wr
  task automatic t_step_rd;
    ack_dly = 2;
    hw(cr, 32'he000_0004);
    bw;
    rc(dr, 32'h0404_0404, "first word");
    bw;
    rc(cr, 32'h6000_0005, "command");
    hw(cr, 32'h4000_0005);
    rc(dr, 32'hdddd_0004, "last word");
    rc(cr, 32'h4000_0005, "command");
    hw(cr, 32'hd000_0000);
    bw;
    rc(dr, 32'hbbbb_0002, "down word");
    bw;
    rc(cr, 32'h5000_ffff, "command");
    hw(cr, 32'h4000_ffff);
    rc(dr, 32'haaaa_0001, "wrapped word");
    $display("test stepped read done");
  endtask : t_step_rd
  task automatic t_reset;
    hw(cr, 32'h7005_0009);
    rc(cr, 32'h7005_0009, "command before reset");
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rc(dr, 32'h0000_0000, "data after reset");
    rc(cr, 32'h0000_0000, "command after reset");
    hw(cr, 32'h4000_0000);
    rc(dr, 32'h0000_0000, "fabric data after reset");
    $display("test reset done");
  endtask : t_reset
  initial
  begin
    rst_n = 1'b0;
    {wr, rd, ack} = 3'h0;
    addr = 12'h000;
    wd = 32'h0000_0000;
    fab_rd = 32'h0000_0000;
    {fail_count, num_checks, wait_c, ack_dly} = '0;
    for (int i = 0; i < 16; i++)
      mem[i] = 32'h0101_0101 * i;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_basic;
    t_step_wr;
    t_step_rd;
    t_reset;
    report_and_stop;
  end
endmodule : tb_top
`default_nettype wire
